// File: rtl/adcrb_bank.v
// Upper control register bank 4h to Fh with its derived control outputs.
//
// Operation
// - Select bit 1: restore nominal, calibrate termination, then linearity.
// - Select bit 0: keep termination, skip its calibration, linearity only.
// - Scan gate bit opens calibration value register 5h to reads and writes.
// - Each calibration stores its result in scan register 5h.
// - Bits 15:9 of 7h trim falling-edge sampling instant, 30 fs steps.
// - Ah gives Q offset: bit 12 sign, bits 11:0 magnitude.
// - Bh bits 14:0 give Q full-scale range, default code 16384.
// - Coarse delay code in Ch saturates at code 2431.
// - Ch bit 3 enables coarse and fine aperture delay codes.
// - Ch bit 2 enables the duty-cycle stabiliser, default on.
// - Dh bits 15:10 add fine clock delay while aperture adjust enabled.
// - Eh bits 15:7 delay reference clock, saturating at code 319.
// - Eh bits 4:3 select latch phase 0, 90, 180 or 270 degrees.
// - Eh bit 2 at 1 makes the device a follower, else master.
// - Eh bit 1 at 0 drives clock divided by four on both outputs.
// - Eh bit 0 at 0 enables the output-clock reset function.
// - Register contents act only in extended control mode, except the 4h scan gate bit.
`timescale 1ns/1ps
module adcrb_bank (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        scs_n,
    input  wire        sclk,
    input  wire        sdi,
    output wire        sdo,
    output wire        sdo_oe,
    input  wire        extended_control_mode,
    input  wire        cal_request,
    input  wire [15:0] cal_result,
    output wire        cal_restore_nominal,
    output wire        cal_termination_run,
    output wire        cal_linearity_run,
    output wire        cal_busy,
    output reg  [6:0]  dual_edge_timing_trim,
    output reg         offset_sign,
    output reg  [11:0] offset_magnitude,
    output reg  [14:0] range_magnitude,
    output reg  [11:0] coarse_delay_code,
    output reg  [5:0]  fine_delay_code,
    output reg         duty_correct_enable,
    output reg  [8:0]  refclk_delay_code,
    output reg  [1:0]  refclk_phase_select,
    output reg         follower_enable,
    output reg         refclk_out_a,
    output reg         refclk_out_b,
    output reg         output_clock_reset
);
`include "adcrb_defs.vh"

////////////////////////////////////////////////////////////////////////////////

wire [3:0]   reg_addr;
wire [15:0]  reg_wdata;
wire         reg_we;
wire         reg_re;
reg  [15:0]  reg_rdata;
wire [255:0] bank_flat;
wire         cal_store;
wire         cal_scan_gate;
wire         cal_sequence_select;

function [15:0] por_of;
    input [3:0] idx;
    begin
        case (idx)
            4'h4:    por_of = `ADCRB_POR_4;
            4'h5:    por_of = `ADCRB_POR_5;
            4'h6:    por_of = `ADCRB_POR_6;
            4'h7:    por_of = `ADCRB_POR_7;
            4'h8:    por_of = `ADCRB_POR_8;
            4'h9:    por_of = `ADCRB_POR_9;
            4'ha:    por_of = `ADCRB_POR_A;
            4'hb:    por_of = `ADCRB_POR_B;
            4'hc:    por_of = `ADCRB_POR_C;
            4'hd:    por_of = `ADCRB_POR_D;
            4'he:    por_of = `ADCRB_POR_E;
            4'hf:    por_of = `ADCRB_POR_F;
            default: por_of = 16'h0000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

adcrb_spi u_spi (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .scs_n     (scs_n),
    .sclk      (sclk),
    .sdi       (sdi),
    .sdo       (sdo),
    .sdo_oe    (sdo_oe),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .reg_re    (reg_re),
    .reg_rdata (reg_rdata)
);

////////////////////////////////////////////////////////////////////////////////

// Registers 0h to 3h live in another block and read back as zero here.
assign bank_flat[63:0] = 64'h0000_0000_0000_0000;

genvar g;
generate
    for (g = 4; g < 16; g = g + 1) begin : g_reg
        localparam [3:0] IDX = g;
        reg [15:0] val_r;
        assign bank_flat[g*16 +: 16] = val_r;
        if (g == 5) begin : g_scan
            // A finishing calibration wins over a host write in the same cycle.
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    val_r <= `ADCRB_POR_5;
                end else if (cal_store) begin
                    val_r <= cal_result;
                end else if (reg_we && reg_addr == IDX && cal_scan_gate) begin
                    val_r <= reg_wdata;
                end
            end
        end else begin : g_ctl
            // Reserved bits are stored as written; the host keeps them at reset values.
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    val_r <= por_of(IDX);
                end else if (reg_we && reg_addr == IDX) begin
                    val_r <= reg_wdata;
                end
            end
        end
    end
endgenerate

always @* begin
    reg_rdata = bank_flat[{reg_addr, 4'h0} +: 16];
    if (reg_addr == `ADCRB_CAL_VAL && !cal_scan_gate) begin
        reg_rdata = 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////////////

// Outside extended control mode every field but the 4h scan gate bit falls back to its reset value.
wire [15:0] eff_cal;
wire [15:0] eff_des;
wire [15:0] eff_ofs;
wire [15:0] eff_fsr;
wire [15:0] eff_crs;
wire [15:0] eff_fin;
wire [15:0] eff_syn;

assign eff_cal = extended_control_mode ? g_reg[4].val_r  : `ADCRB_POR_4;
assign eff_des = extended_control_mode ? g_reg[7].val_r  : `ADCRB_POR_7;
assign eff_ofs = extended_control_mode ? g_reg[10].val_r : `ADCRB_POR_A;
assign eff_fsr = extended_control_mode ? g_reg[11].val_r : `ADCRB_POR_B;
assign eff_crs = extended_control_mode ? g_reg[12].val_r : `ADCRB_POR_C;
assign eff_fin = extended_control_mode ? g_reg[13].val_r : `ADCRB_POR_D;
assign eff_syn = extended_control_mode ? g_reg[14].val_r : `ADCRB_POR_E;

// The scan gate is a register-access feature, so it follows the raw bit.
assign cal_scan_gate       = g_reg[4].val_r[`ADCRB_BIT_SCAN];
assign cal_sequence_select = eff_cal[`ADCRB_BIT_SEQ_SEL];

adcrb_cal u_cal (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .cal_request         (cal_request),
    .cal_sequence_select (cal_sequence_select),
    .cal_restore_nominal (cal_restore_nominal),
    .cal_termination_run (cal_termination_run),
    .cal_linearity_run   (cal_linearity_run),
    .cal_busy            (cal_busy),
    .cal_store           (cal_store)
);

////////////////////////////////////////////////////////////////////////////////

wire        apt_en;
wire [11:0] coarse_raw;
wire [11:0] coarse_sat;
wire [8:0]  refdly_raw;
wire [8:0]  refdly_sat;
reg  [1:0]  div_r;

assign apt_en     = eff_crs[`ADCRB_BIT_APT_EN];
assign coarse_raw = eff_crs[15:4];
assign coarse_sat = (coarse_raw > `ADCRB_COARSE_MAX) ? `ADCRB_COARSE_MAX : coarse_raw;
assign refdly_raw = eff_syn[15:7];
assign refdly_sat = (refdly_raw > `ADCRB_REFDLY_MAX) ? `ADCRB_REFDLY_MAX : refdly_raw;

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        dual_edge_timing_trim <= 7'h40;
        offset_sign           <= 1'b0;
        offset_magnitude      <= 12'h000;
        range_magnitude       <= 15'h4000;
        coarse_delay_code     <= 12'h000;
        fine_delay_code       <= 6'h00;
        duty_correct_enable   <= 1'b1;
        refclk_delay_code     <= 9'h000;
        refclk_phase_select   <= 2'h0;
        follower_enable       <= 1'b0;
        output_clock_reset    <= 1'b0;
        div_r                 <= 2'h0;
        refclk_out_a          <= 1'b0;
        refclk_out_b          <= 1'b0;
    end else begin
        dual_edge_timing_trim <= eff_des[15:9];
        offset_sign           <= eff_ofs[`ADCRB_BIT_OSIGN];
        offset_magnitude      <= eff_ofs[11:0];
        range_magnitude       <= eff_fsr[14:0];
        coarse_delay_code     <= apt_en ? coarse_sat : 12'h000;
        fine_delay_code       <= apt_en ? eff_fin[15:10] : 6'h00;
        duty_correct_enable   <= eff_crs[`ADCRB_BIT_DUTY];
        refclk_delay_code     <= refdly_sat;
        refclk_phase_select   <= eff_syn[4:3];
        follower_enable       <= eff_syn[`ADCRB_BIT_FOLLOW];
        output_clock_reset    <= ~eff_syn[`ADCRB_BIT_SRST_DIS];
        div_r                 <= div_r + 2'h1;
        // Divided clock stands low while the output drivers are disabled.
        refclk_out_a          <= ~eff_syn[`ADCRB_BIT_RCO_DIS] & div_r[1];
        refclk_out_b          <= ~eff_syn[`ADCRB_BIT_RCO_DIS] & div_r[1];
    end
end

endmodule // adcrb_bank

// File: rtl/adcrb_defs.vh
// Register offsets, field positions, reset values and timing counts of the bank.
`ifndef ADCRB_DEFS_VH
`define ADCRB_DEFS_VH

`define ADCRB_CAL_ADJ       4'h4
`define ADCRB_CAL_VAL       4'h5
`define ADCRB_DES_ADJ       4'h7
`define ADCRB_Q_OFS         4'ha
`define ADCRB_Q_FSR         4'hb
`define ADCRB_APT_COARSE    4'hc
`define ADCRB_APT_FINE      4'hd
`define ADCRB_SYNC          4'he

`define ADCRB_POR_4         16'hdf4b
`define ADCRB_POR_5         16'h0000
`define ADCRB_POR_6         16'h1c20
`define ADCRB_POR_7         16'h8140
`define ADCRB_POR_8         16'h0000
`define ADCRB_POR_9         16'h0000
`define ADCRB_POR_A         16'h0000
`define ADCRB_POR_B         16'h4000
`define ADCRB_POR_C         16'h0004
`define ADCRB_POR_D         16'h0000
`define ADCRB_POR_E         16'h0003
`define ADCRB_POR_F         16'h0018

`define ADCRB_BIT_SEQ_SEL   14
`define ADCRB_BIT_SCAN      7
`define ADCRB_BIT_OSIGN     12
`define ADCRB_BIT_APT_EN    3
`define ADCRB_BIT_DUTY      2
`define ADCRB_BIT_FOLLOW    2
`define ADCRB_BIT_RCO_DIS   1
`define ADCRB_BIT_SRST_DIS  0

`define ADCRB_COARSE_MAX    12'h097f
`define ADCRB_REFDLY_MAX    9'h13f

`define ADCRB_CAL_STEP_CYC  8'h10
`define ADCRB_HDR_LAST      5'h07
`define ADCRB_FRAME_LAST    5'h17

`endif

// File: rtl/adcrb_cal.v
// Calibration sequencer: restore, termination and linearity phases.
`timescale 1ns/1ps
module adcrb_cal (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        cal_request,
    input  wire        cal_sequence_select,
    output reg         cal_restore_nominal,
    output reg         cal_termination_run,
    output reg         cal_linearity_run,
    output wire        cal_busy,
    output reg         cal_store
);
`include "adcrb_defs.vh"

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_REST = 3'h1;
localparam [2:0] ST_TERM = 3'h2;
localparam [2:0] ST_LIN  = 3'h3;

reg  [2:0] state_r;
reg  [7:0] step_cnt_r;
reg        req_prev_r;
wire       start;
wire       step_end;

assign start    = cal_request & ~req_prev_r;
assign step_end = (step_cnt_r == `ADCRB_CAL_STEP_CYC - 8'h01);
assign cal_busy = (state_r != ST_IDLE);

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        state_r    <= ST_IDLE;
        step_cnt_r <= 8'h00;
        req_prev_r <= 1'b0;
        cal_store  <= 1'b0;
    end else begin
        req_prev_r <= cal_request;
        cal_store  <= 1'b0;
        step_cnt_r <= cal_busy ? step_cnt_r + 8'h01 : 8'h00;
        if (cal_busy && step_end) begin
            step_cnt_r <= 8'h00;
        end
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_r <= cal_sequence_select ? ST_REST : ST_LIN;
                end
            end
            ST_REST: begin
                if (step_end) begin
                    state_r <= ST_TERM;
                end
            end
            ST_TERM: begin
                if (step_end) begin
                    state_r <= ST_LIN;
                end
            end
            ST_LIN: begin
                if (step_end) begin
                    state_r   <= ST_IDLE;
                    cal_store <= 1'b1;
                end
            end
            default: begin
                state_r <= ST_IDLE;
            end
        endcase
    end
end

always @* begin
    cal_restore_nominal = (state_r == ST_REST);
    cal_termination_run = (state_r == ST_TERM);
    cal_linearity_run   = (state_r == ST_LIN);
end

endmodule // adcrb_cal

// File: rtl/adcrb_spi.v
// Serial control port slave: frames of 8 header bits and 16 data bits.
`timescale 1ns/1ps
module adcrb_spi (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        scs_n,
    input  wire        sclk,
    input  wire        sdi,
    output reg         sdo,
    output reg         sdo_oe,
    output reg  [3:0]  reg_addr,
    output reg  [15:0] reg_wdata,
    output reg         reg_we,
    output reg         reg_re,
    input  wire [15:0] reg_rdata
);
`include "adcrb_defs.vh"

wire [2:0]  pins;
reg  [2:0]  filt_r;
reg  [2:0]  prev_r;
reg  [22:0] shift_r;
reg  [15:0] out_r;
reg  [4:0]  cnt_r;
reg         rw_r;
wire        cs_act;
wire        rise;
wire        fall;

assign pins = {scs_n, sclk, sdi};

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
        reg [2:0] s_r;
        // A change is taken only when the second and third stages agree.
        always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                s_r       <= (g == 2) ? 3'h7 : 3'h0;
                filt_r[g] <= (g == 2);
            end else begin
                s_r <= {s_r[1:0], pins[g]};
                if (s_r[1] == s_r[2]) begin
                    filt_r[g] <= s_r[2];
                end
            end
        end
    end
endgenerate

assign cs_act = ~filt_r[2];
assign rise   = filt_r[1] & ~prev_r[1];
assign fall   = ~filt_r[1] & prev_r[1];

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        prev_r    <= 3'h4;
        shift_r   <= 23'h00_0000;
        out_r     <= 16'h0000;
        cnt_r     <= 5'h00;
        rw_r      <= 1'b0;
        reg_addr  <= 4'h0;
        reg_wdata <= 16'h0000;
        reg_we    <= 1'b0;
        reg_re    <= 1'b0;
        sdo       <= 1'b0;
        sdo_oe    <= 1'b0;
    end else begin
        prev_r <= filt_r;
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        if (reg_re) begin
            out_r <= reg_rdata;
        end
        if (!cs_act) begin
            cnt_r  <= 5'h00;
            sdo_oe <= 1'b0;
        end else if (rise && cnt_r <= `ADCRB_FRAME_LAST) begin
            shift_r <= {shift_r[21:0], filt_r[0]};
            cnt_r   <= cnt_r + 5'h01;
            if (cnt_r == `ADCRB_HDR_LAST) begin
                rw_r     <= shift_r[6];
                reg_addr <= {shift_r[2:0], filt_r[0]};
                reg_re   <= shift_r[6];
                sdo_oe   <= shift_r[6];
            end
            if (cnt_r == `ADCRB_FRAME_LAST && !rw_r) begin
                reg_wdata <= {shift_r[14:0], filt_r[0]};
                reg_we    <= 1'b1;
            end
        end else if (fall && sdo_oe) begin
            sdo   <= out_r[15];
            out_r <= {out_r[14:0], 1'b0};
        end
    end
end

endmodule // adcrb_spi

// File: tb/adcrb_host.sv
// Host model that drives whole frames on the serial control port.
`timescale 1ns/1ps
module adcrb_host (
    input  wire sys_clk,
    output reg  scs_n,
    output reg  sclk,
    output reg  sdi,
    input  wire sdo
);
    initial begin
        scs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task wt(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Each clock phase lasts six cycles so the device's input filter always sees it.
    task frame(input rd, input [3:0] a, input [15:0] wd, output [15:0] rdat);
        reg [23:0] sh;
        integer i;
        begin
            sh = {rd, 3'h0, a, wd};
            rdat = 16'h0000;
            @(posedge sys_clk) scs_n <= 1'b0;
            wt(6);
            for (i = 0; i < 24; i++) begin
                sdi <= sh[23 - i];
                wt(6);
                if (i >= 8) rdat = {rdat[14:0], sdo};
                sclk <= 1'b1;
                wt(6);
                sclk <= 1'b0;
            end
            wt(6);
            scs_n <= 1'b1;
            // The data line never rests on the last bit sent.
            sdi <= ~sdi;
            wt(8);
        end
    endtask
endmodule // adcrb_host

// File: tb/adcrb_chk_monitor.sv
// Checker of the bank's derived outputs and calibration phases.
`timescale 1ns/1ps
module adcrb_chk (
    input wire        sys_clk,
    input wire        rst,
    input wire        scs_n,
    input wire        extended_control_mode,
    input wire        cal_busy,
    input wire        cal_restore_nominal,
    input wire        cal_termination_run,
    input wire        cal_linearity_run,
    input wire        refclk_out_a,
    input wire        refclk_out_b,
    input wire [11:0] coarse_delay_code,
    input wire [8:0]  refclk_delay_code,
    input wire        duty_correct_enable,
    input wire [14:0] range_magnitude,
    input wire [11:0] offset_magnitude
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_to_term;
        !cal_restore_nominal && cal_termination_run;
    endsequence
    sequence s_to_lin;
        !cal_termination_run && cal_linearity_run;
    endsequence
    sequence s_lin_phase;
        (cal_busy && cal_linearity_run)[*8] ##9 !cal_linearity_run;
    endsequence

    property p_restore_order;
        $fell(cal_restore_nominal) |-> s_to_term;
    endproperty
    property p_term_order;
        $fell(cal_termination_run) |-> s_to_lin;
    endproperty
    property p_lin_len;
        $rose(cal_linearity_run) |-> s_lin_phase;
    endproperty
    property p_rco_pair;
        refclk_out_a == refclk_out_b;
    endproperty
    property p_rco_div;
        refclk_out_a ##1 refclk_out_a |=> !refclk_out_a;
    endproperty
    property p_ecm_rco;
        !extended_control_mode |=> !refclk_out_a;
    endproperty
    property p_ecm_fields;
        !extended_control_mode |=> duty_correct_enable && range_magnitude == 15'h4000
            && coarse_delay_code == 12'h000 && offset_magnitude == 12'h000;
    endproperty
    property p_coarse_sat;
        coarse_delay_code <= 12'h097f;
    endproperty
    property p_refdly_sat;
        refclk_delay_code <= 9'h13f;
    endproperty
    property p_hold;
        scs_n[*8] ##0 $stable(extended_control_mode) |=>
            $stable(range_magnitude) && $stable(offset_magnitude);
    endproperty

    a_restore_order: assert property (p_restore_order) else $error("restore not followed by termination");
    a_term_order: assert property (p_term_order) else $error("termination not followed by linearity");
    a_lin_len: assert property (p_lin_len) else $error("linearity phase length wrong");
    a_rco_pair: assert property (p_rco_pair) else $error("reference outputs differ");
    a_rco_div: assert property (p_rco_div) else $error("reference output high too long");
    a_ecm_rco: assert property (p_ecm_rco) else $error("reference output active outside extended mode");
    a_ecm_fields: assert property (p_ecm_fields) else $error("fields not at defaults outside extended mode");
    a_coarse_sat: assert property (p_coarse_sat) else $error("coarse delay above saturation");
    a_refdly_sat: assert property (p_refdly_sat) else $error("reference delay above saturation");
    a_hold: assert property (p_hold) else $error("field changed without a write");
endmodule // adcrb_chk

bind adcrb_bank adcrb_chk u_chk (
    .sys_clk(sys_clk), .rst(rst), .scs_n(scs_n),
    .extended_control_mode(extended_control_mode), .cal_busy(cal_busy),
    .cal_restore_nominal(cal_restore_nominal), .cal_termination_run(cal_termination_run),
    .cal_linearity_run(cal_linearity_run), .refclk_out_a(refclk_out_a),
    .refclk_out_b(refclk_out_b), .coarse_delay_code(coarse_delay_code),
    .refclk_delay_code(refclk_delay_code), .duty_correct_enable(duty_correct_enable),
    .range_magnitude(range_magnitude), .offset_magnitude(offset_magnitude)
);

// File: tb/adc_control_register_bank_upper_bench.sv
// Self-checking bench of the upper control register bank.
`timescale 1ns/1ps
`include "adcrb_defs.vh"
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module adc_control_register_bank_upper_bench;
    reg         sys_clk, rst, extended_control_mode, cal_request;
    reg  [15:0] cal_result, rd;
    wire        scs_n, sclk, sdi, sdo, cal_busy, cal_restore_nominal;
    wire        cal_termination_run, cal_linearity_run, offset_sign, duty_correct_enable;
    wire        follower_enable, refclk_out_a, refclk_out_b, output_clock_reset;
    wire [6:0]  dual_edge_timing_trim;
    wire [11:0] offset_magnitude, coarse_delay_code;
    wire [14:0] range_magnitude;
    wire [5:0]  fine_delay_code;
    wire [8:0]  refclk_delay_code;
    wire [1:0]  refclk_phase_select;
    integer     errors, n_tests, i;
    reg  [35:0] rows [0:10];
    reg  [15:0] por [4:15];

    adcrb_bank u_dut (
        .sys_clk(sys_clk), .rst(rst), .scs_n(scs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(), .extended_control_mode(extended_control_mode), .cal_request(cal_request),
        .cal_result(cal_result), .cal_restore_nominal(cal_restore_nominal),
        .cal_termination_run(cal_termination_run), .cal_linearity_run(cal_linearity_run),
        .cal_busy(cal_busy), .dual_edge_timing_trim(dual_edge_timing_trim),
        .offset_sign(offset_sign), .offset_magnitude(offset_magnitude),
        .range_magnitude(range_magnitude), .coarse_delay_code(coarse_delay_code),
        .fine_delay_code(fine_delay_code), .duty_correct_enable(duty_correct_enable),
        .refclk_delay_code(refclk_delay_code), .refclk_phase_select(refclk_phase_select),
        .follower_enable(follower_enable), .refclk_out_a(refclk_out_a),
        .refclk_out_b(refclk_out_b), .output_clock_reset(output_clock_reset)
    );
    adcrb_host u_host (.sys_clk(sys_clk), .scs_n(scs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function [15:0] seen(input [3:0] a);
        case (a)
            4'h7: seen = {9'h000, dual_edge_timing_trim};
            4'ha: seen = {3'h0, offset_sign, offset_magnitude};
            4'hb: seen = {1'b0, range_magnitude};
            4'hc: seen = {coarse_delay_code, 3'h0, duty_correct_enable};
            4'hd: seen = {10'h000, fine_delay_code};
            default: seen = {refclk_delay_code, 3'h0, refclk_phase_select, follower_enable,
                             output_clock_reset};
        endcase
    endfunction

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Sequence lengths are counted here, phase order is left to the checker.
    task run_cal(input [15:0] v, input integer busy_n, input integer term_n);
        integer n, t;
        begin
            n = 0;
            t = 0;
            cal_result <= v;
            cal_request <= 1'b1;
            while (cal_busy !== 1'b1 && n < 20) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            if (n == 20) begin
                errors++;
                give_verdict;
            end
            n = 0;
            while (cal_busy === 1'b1 && n < 200) begin
                @(posedge sys_clk);
                cal_request <= 1'b0;
                #1;
                n++;
                if (cal_termination_run === 1'b1) t++;
            end
            `CHECK("busy cycles", busy_n, n)
            `CHECK("termination cycles", term_n, t)
            u_host.wt(2);
        end
    endtask

    initial begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        extended_control_mode = 1'b0;
        cal_request = 1'b0;
        cal_result = 16'h0000;
        // Reserved bits are always written with their power-on values.
        rows = '{36'h7_ab40_0055, 36'ha_1fff_1fff, 36'hb_7fff_7fff, 36'hc_fff0_0000,
                 36'hc_9808_97f0, 36'hc_97fc_97f1, 36'hd_fc00_003f, 36'he_ff9f_9f8e,
                 36'he_0008_0005, 36'he_0010_0009, 36'he_0002_0001};
        por = '{`ADCRB_POR_4, `ADCRB_POR_5, `ADCRB_POR_6, `ADCRB_POR_7, `ADCRB_POR_8,
                `ADCRB_POR_9, `ADCRB_POR_A, `ADCRB_POR_B, `ADCRB_POR_C, `ADCRB_POR_D,
                `ADCRB_POR_E, `ADCRB_POR_F};
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        u_host.wt(4);
        `CHECK("range outside extended mode", 15'h4000, range_magnitude)
        `CHECK("duty outside extended mode", 1'b1, duty_correct_enable)
        for (i = 4; i < 16; i++) begin
            u_host.frame(1'b1, i[3:0], 16'h5555, rd);
            `CHECK("power-on value", por[i], rd)
        end
        u_host.frame(1'b1, 4'h2, 16'h5555, rd);
        `CHECK("unmapped read", 16'h0000, rd)
        @(posedge sys_clk) extended_control_mode <= 1'b1;
        for (i = 0; i < 11; i++) begin
            u_host.frame(1'b0, rows[i][35:32], rows[i][31:16], rd);
            `CHECK("field", rows[i][15:0], seen(rows[i][35:32]))
            u_host.frame(1'b1, rows[i][35:32], 16'h5555, rd);
            `CHECK("readback", rows[i][31:16], rd)
        end
        u_host.frame(1'b0, 4'h5, 16'h1234, rd);
        u_host.frame(1'b1, 4'h5, 16'h5555, rd);
        `CHECK("scan closed", 16'h0000, rd)
        u_host.frame(1'b0, 4'h4, 16'hdfcb, rd);
        u_host.frame(1'b0, 4'h5, 16'h1234, rd);
        u_host.frame(1'b1, 4'h5, 16'h5555, rd);
        `CHECK("scan open", 16'h1234, rd)
        run_cal(16'hbeef, 48, 16);
        u_host.frame(1'b1, 4'h5, 16'h5555, rd);
        `CHECK("stored full", 16'hbeef, rd)
        u_host.frame(1'b0, 4'h4, 16'h9fcb, rd);
        run_cal(16'h5a5a, 16, 0);
        u_host.frame(1'b1, 4'h5, 16'h5555, rd);
        `CHECK("stored short", 16'h5a5a, rd)
        u_host.frame(1'b0, 4'h4, `ADCRB_POR_4, rd);
        @(posedge sys_clk) extended_control_mode <= 1'b0;
        u_host.wt(3);
        `CHECK("range extended mode off", 15'h4000, range_magnitude)
        extended_control_mode <= 1'b1;
        u_host.wt(3);
        `CHECK("range kept", 15'h7fff, range_magnitude)
        rst <= 1'b1;
        u_host.wt(2);
        rst <= 1'b0;
        u_host.wt(4);
        `CHECK("range after reset", 15'h4000, range_magnitude)
        u_host.frame(1'b1, 4'hb, 16'h5555, rd);
        `CHECK("full scale after reset", `ADCRB_POR_B, rd)
        give_verdict;
    end
endmodule // adc_control_register_bank_upper_bench
